// ==== rtl/ssrp_pkg.sv ====
// Constants and carrier types of the serial slave register port
package ssrp_pkg;
  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h68;  // 1101000
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam int PTR_W = 6;
  localparam logic [5:0] PTR_RESET = 6'h00;
  localparam logic [5:0] PTR_LAST = 6'h3F;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSRP_IDLE = 3'b000,
    SSRP_ADDR = 3'b001,
    SSRP_PTR = 3'b010,
    SSRP_WDATA = 3'b011,
    SSRP_RDATA = 3'b100,
    SSRP_IGNORE = 3'b101
  } ssrp_state_t;

  // Sampled bus events, one clk cycle each; sda is the filtered data level
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } ssrp_bus_ev_t;

  // Register file side
  typedef struct packed {
    logic [5:0] ptr;
    logic [7:0] wdata;
    logic wstrobe;
    logic shadow;
  } ssrp_reg_req_t;
endpackage : ssrp_pkg

// ==== rtl/ssrp_sync.sv ====
// Pin synchroniser and edge/condition detector for the two bus lines
`timescale 1ns/1ps
module ssrp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Events
  output ssrp_pkg::ssrp_bus_ev_t ev
);
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_st;
  logic sda_st;
  logic [2:0] next_scl_sync;
  logic [2:0] next_sda_sync;
  logic next_scl_st;
  logic next_sda_st;
  ssrp_pkg::ssrp_bus_ev_t next_ev;

  // ----------------------------------------------------------------
  // Three-stage sampling; a change counts when stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_scl_sync = {scl_sync[1:0], scl_in};
    next_sda_sync = {sda_sync[1:0], sda_in};
    next_scl_st = scl_st;
    next_sda_st = sda_st;
    if (scl_sync[1] == scl_sync[2]) begin
      next_scl_st = scl_sync[2];
    end
    if (sda_sync[1] == sda_sync[2]) begin
      next_sda_st = sda_sync[2];
    end
    next_ev.scl_rise = next_scl_st & ~scl_st;
    next_ev.scl_fall = ~next_scl_st & scl_st;
    // Conditions need clock high and stable across the data change
    next_ev.start = scl_st & next_scl_st & sda_st & ~next_sda_st;
    next_ev.stop = scl_st & next_scl_st & ~sda_st & next_sda_st;
    next_ev.sda = next_sda_st;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sync <= ssrp_pkg::SYNC_RESET;
      sda_sync <= ssrp_pkg::SYNC_RESET;
      scl_st <= 1'b1;
      sda_st <= 1'b1;
      ev <= '0;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_st <= next_scl_st;
      sda_st <= next_sda_st;
      ev <= next_ev;
    end
  end
endmodule : ssrp_sync

// ==== rtl/ssrp_top.sv ====
// Serial slave register port: bus front end of a clock/calendar register file
`timescale 1ns/1ps
module ssrp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins (open drain; clock is input only)
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register file
  input wire logic [7:0] reg_rdata,
  output ssrp_pkg::ssrp_reg_req_t reg_req
);
  ssrp_pkg::ssrp_bus_ev_t ev;
  ssrp_pkg::ssrp_state_t state;
  ssrp_pkg::ssrp_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic ack_phase;
  logic next_ack_phase;
  logic [5:0] ptr;
  logic [5:0] next_ptr;
  logic next_sda_oe;
  ssrp_pkg::ssrp_reg_req_t next_reg_req;

  ssrp_sync u_sync (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // Byte engine: bits counted on clock edges, ack slot is the ninth bit
  // ----------------------------------------------------------------
  // Drive changes only on falling clock, apart from the release at START or STOP, so data is stable while high.
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ack_phase = ack_phase;
    next_ptr = ptr;
    next_sda_oe = sda_oe;
    next_reg_req = reg_req;
    next_reg_req.wstrobe = 1'b0;
    next_reg_req.shadow = 1'b0;
    if (ev.start) begin
      // Any START, repeated or not, drops the partial byte
      next_state = ssrp_pkg::SSRP_ADDR;
      next_bit_cnt = ssrp_pkg::BIT_RESET;
      next_ack_phase = 1'b0;
      next_sda_oe = 1'b0;
      next_reg_req.shadow = 1'b1;
    end else if (ev.stop) begin
      next_state = ssrp_pkg::SSRP_IDLE;
      next_bit_cnt = ssrp_pkg::BIT_RESET;
      next_ack_phase = 1'b0;
      next_sda_oe = 1'b0;
      next_reg_req.shadow = 1'b1;
    end else if (state != ssrp_pkg::SSRP_IDLE && state != ssrp_pkg::SSRP_IGNORE) begin
      if (ev.scl_rise && !ack_phase && state != ssrp_pkg::SSRP_RDATA) begin
        // Receive: shift in MSB first
        next_shreg = {shreg[6:0], ev.sda};
        next_bit_cnt = bit_cnt + 4'h1;
      end else if (ev.scl_rise && ack_phase && state == ssrp_pkg::SSRP_RDATA) begin
        // Master's answer to our byte
        if (ev.sda) begin
          next_state = ssrp_pkg::SSRP_IGNORE;
        end
      end else if (ev.scl_rise && ack_phase && state == ssrp_pkg::SSRP_WDATA) begin
        next_reg_req.wstrobe = 1'b1;
      end else if (ev.scl_rise && !ack_phase && state == ssrp_pkg::SSRP_RDATA) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end else if (ev.scl_fall && !ack_phase && bit_cnt == 4'h8) begin
        // End of eighth bit: decide the ninth
        next_ack_phase = 1'b1;
        next_bit_cnt = ssrp_pkg::BIT_RESET;
        next_sda_oe = 1'b0;
        case (state)
          ssrp_pkg::SSRP_ADDR: begin
            if (shreg[7:1] == ssrp_pkg::SLAVE_ADDR) begin
              next_sda_oe = 1'b1;
            end else begin
              next_state = ssrp_pkg::SSRP_IGNORE;
              next_ack_phase = 1'b0;
            end
          end
          ssrp_pkg::SSRP_PTR: begin
            next_ptr = shreg[5:0];
            next_sda_oe = 1'b1;
          end
          ssrp_pkg::SSRP_WDATA: begin
            next_reg_req.ptr = ptr;
            next_reg_req.wdata = shreg;
            next_sda_oe = 1'b1;
          end
          default: begin
            // Read byte sent: release so master can answer
            next_ptr = ptr + 6'h01;
            next_reg_req.shadow = (ptr == ssrp_pkg::PTR_LAST);
          end
        endcase
      end else if (ev.scl_fall && ack_phase) begin
        // Ninth bit over: start next byte
        next_ack_phase = 1'b0;
        next_sda_oe = 1'b0;
        case (state)
          ssrp_pkg::SSRP_ADDR: begin
            if (shreg[0] == ssrp_pkg::DIR_READ) begin
              next_state = ssrp_pkg::SSRP_RDATA;
            end else begin
              next_state = ssrp_pkg::SSRP_PTR;
            end
          end
          ssrp_pkg::SSRP_PTR: begin
            next_state = ssrp_pkg::SSRP_WDATA;
          end
          ssrp_pkg::SSRP_WDATA: begin
            next_ptr = ptr + 6'h01;
            next_reg_req.shadow = (ptr == ssrp_pkg::PTR_LAST);
          end
          default: begin
          end
        endcase
        if (next_state == ssrp_pkg::SSRP_RDATA) begin
          // Load byte at the pointer; first bit out is MSB
          next_shreg = reg_rdata;
          next_sda_oe = ~reg_rdata[7];
          // Count from zero so that eight clocks send eight bits before the answer slot
          next_bit_cnt = ssrp_pkg::BIT_RESET;
        end
      end else if (ev.scl_fall && state == ssrp_pkg::SSRP_RDATA) begin
        if (bit_cnt != 4'h8) begin
          next_shreg = {shreg[6:0], 1'b0};
          next_sda_oe = ~shreg[6];
        end
      end
    end
    next_reg_req.ptr = (next_reg_req.wstrobe) ? reg_req.ptr : next_ptr;
    if (next_state == ssrp_pkg::SSRP_WDATA && ev.scl_fall && !ack_phase && bit_cnt == 4'h8) begin
      next_reg_req.ptr = ptr;
    end else if (ack_phase && state == ssrp_pkg::SSRP_WDATA) begin
      next_reg_req.ptr = ptr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ssrp_pkg::SSRP_IDLE;
      bit_cnt <= ssrp_pkg::BIT_RESET;
      shreg <= ssrp_pkg::BYTE_RESET;
      ack_phase <= 1'b0;
      ptr <= ssrp_pkg::PTR_RESET;
      sda_oe <= 1'b0;
      reg_req <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ack_phase <= next_ack_phase;
      ptr <= next_ptr;
      sda_oe <= next_sda_oe;
      reg_req <= next_reg_req;
    end
  end

  // Open drain: only ever drives low; clock pin has no output at all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start;
    ev.start;
  endsequence

  chk_start_restarts: assert property (@(posedge clk) disable iff (rst)
    s_start |=> state == ssrp_pkg::SSRP_ADDR && !sda_oe)
    else $error("START did not restart address phase");
  chk_stop_idle: assert property (@(posedge clk) disable iff (rst)
    ev.stop |=> state == ssrp_pkg::SSRP_IDLE && !sda_oe)
    else $error("STOP did not return to idle");
  chk_ignore_quiet: assert property (@(posedge clk) disable iff (rst)
    state == ssrp_pkg::SSRP_IGNORE |-> !sda_oe)
    else $error("data driven while ignoring");
  chk_addr_ack: assert property (@(posedge clk) disable iff (rst)
    state == ssrp_pkg::SSRP_ADDR && ack_phase && sda_oe |-> shreg[7:1] == ssrp_pkg::SLAVE_ADDR)
    else $error("ack for wrong address");
  chk_nack_release: assert property (@(posedge clk) disable iff (rst)
    state == ssrp_pkg::SSRP_RDATA && ack_phase && ev.scl_rise && ev.sda
    |=> state == ssrp_pkg::SSRP_IGNORE ##1 !sda_oe)
    else $error("no release after not-acknowledge");
  chk_wstrobe_pulse: assert property (@(posedge clk) disable iff (rst)
    reg_req.wstrobe |=> !reg_req.wstrobe)
    else $error("write strobe longer than one cycle");
  chk_ptr_load: assert property (@(posedge clk) disable iff (rst)
    state == ssrp_pkg::SSRP_PTR && ev.scl_fall && !ack_phase && bit_cnt == 4'h8
    |=> ptr == $past(shreg[5:0]))
    else $error("pointer not loaded");
  chk_ptr_wrap: assert property (@(posedge clk) disable iff (rst)
    ptr == ssrp_pkg::PTR_LAST && next_ptr != ptr && !(state == ssrp_pkg::SSRP_PTR)
    |=> ptr == ssrp_pkg::PTR_RESET && reg_req.shadow)
    else $error("pointer wrap wrong");
  chk_write_dir: assert property (@(posedge clk) disable iff (rst)
    state == ssrp_pkg::SSRP_ADDR && ack_phase && ev.scl_fall && !ev.start && !ev.stop
    && shreg[0] == ssrp_pkg::DIR_WRITE |=> state == ssrp_pkg::SSRP_PTR)
    else $error("write direction not taken");
endmodule : ssrp_top

// ==== verif/ssrp_master.sv ====
// Bus master model that clocks the serial port from the far side
`timescale 1ns/1ps
module ssrp_master (
  // Clock and resolved data line
  input wire logic clk,
  input wire logic sda,
  // Driven lines
  output logic scl,
  output logic sda_low
);
  // --------------------------------------------------------------
  // Bus timing: a quarter bit is four clk cycles
  // --------------------------------------------------------------
  localparam int Q = 4;

  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic qw(input int n);
    repeat (n * Q) @(negedge clk);
  endtask : qw

  // Wait a quarter after the clock falls so data never moves near an edge
  task automatic start;
    qw(1);
    sda_low = 1'b0;
    qw(1);
    scl = 1'b1;
    qw(2);
    sda_low = 1'b1;
    qw(2);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    qw(1);
    sda_low = 1'b1;
    qw(1);
    scl = 1'b1;
    qw(2);
    sda_low = 1'b0;
    qw(2);
  endtask : stop

  // One clock pulse; line sampled in mid high phase
  task automatic bit_cycle(input logic low, output logic seen);
    qw(1);
    sda_low = low;
    qw(1);
    scl = 1'b1;
    qw(1);
    seen = sda;
    qw(1);
    scl = 1'b0;
  endtask : bit_cycle

  // Fewer than eight bits leaves a partial byte with no ninth clock
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    logic s;
    for (int i = 7; i > 7 - n; i--) bit_cycle(~b[i], s);
    ack = 1'b0;
    if (n == 8) begin
      bit_cycle(1'b0, s);
      ack = ~s;
    end
  endtask : send

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, s);
      b[i] = s;
    end
    bit_cycle(~last, s);
  endtask : recv
endmodule : ssrp_master

// ==== verif/serial_slave_register_port_bench.sv ====
// Self-checking bench of the serial slave register port
`timescale 1ns/1ps
module serial_slave_register_port_bench;
  // --------------------------------------------------------------
  // Signals and register file model
  // --------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic m_low;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic [7:0] reg_rdata;
  ssrp_pkg::ssrp_reg_req_t reg_req;
  logic [7:0] mem [64];
  int mismatches = 0;
  int total_checks = 0;
  int shadows = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;
  // Open-drain data wire with pull-up; the port drives its output level only while enabled
  assign sda = ~m_low & (sda_oe ? sda_out : 1'b1);
  assign reg_rdata = mem[reg_req.ptr];

  // Register file writes and shadow pulse count
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reg_req.wstrobe) mem[reg_req.ptr] <= reg_req.wdata;
    if (reg_req.shadow) shadows <= shadows + 1;
  end

  ssrp_top i_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .reg_rdata(reg_rdata), .reg_req(reg_req));
  ssrp_master i_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic byte_out(input logic [7:0] b, input logic exp_ack, input string what);
    logic a;
    i_master.send(b, 8, a);
    check({7'h00, a}, {7'h00, exp_ack}, what);
  endtask : byte_out

  task automatic byte_in(input logic last, input logic [7:0] exp, input string what);
    logic [7:0] b;
    i_master.recv(last, b);
    check(b, exp, what);
  endtask : byte_in

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic read_from_reset;
    // Byte after the last read opens with a 0 bit, so a missed release would show
    mem[2] = 8'h00;
    i_master.start();
    byte_out(8'hD1, 1'b1, "read address");
    check({7'h00, sda_out}, 8'h00, "open-drain low level");
    byte_in(1'b0, 8'h80, "first read");
    byte_in(1'b1, 8'h81, "second read");
    repeat (8) @(negedge clk);
    check({7'h00, sda_oe}, 8'h00, "release after no-ack");
    check({7'h00, sda}, 8'h01, "data line released");
    i_master.stop();
  endtask : read_from_reset

  // Burst across the top of the map: start, wrap and stop each copy time
  task automatic write_wrap;
    int s0;
    s0 = shadows;
    i_master.start();
    byte_out(8'hD0, 1'b1, "write address");
    byte_out(8'h3E, 1'b1, "pointer");
    byte_out(8'hA5, 1'b1, "data 0");
    byte_out(8'h3C, 1'b1, "data 1");
    byte_out(8'h96, 1'b1, "data 2");
    i_master.stop();
    check(mem[62], 8'hA5, "reg 3E");
    check(mem[63], 8'h3C, "reg 3F");
    check(mem[0], 8'h96, "reg 00");
    check(8'(shadows - s0), 8'h03, "shadow pulses");
    i_master.start();
    byte_out(8'hD1, 1'b1, "read address");
    byte_in(1'b1, 8'h81, "retained pointer");
    i_master.stop();
  endtask : write_wrap

  task automatic pointer_then_read;
    i_master.start();
    byte_out(8'hD0, 1'b1, "write address");
    byte_out(8'h10, 1'b1, "pointer");
    i_master.start();
    byte_out(8'hD1, 1'b1, "address after restart");
    byte_in(1'b0, 8'h90, "reg 10");
    byte_in(1'b1, 8'h91, "reg 11");
    i_master.stop();
  endtask : pointer_then_read

  // Two one-bit-off addresses and a bit-reversed one are all ignored
  task automatic foreign_addr;
    logic [7:0] addrs [3] = '{8'hD2, 8'h17, 8'h50};
    foreach (addrs[i]) begin
      i_master.start();
      byte_out(addrs[i], 1'b0, "foreign address");
      byte_out(8'h05, 1'b0, "ignored byte");
      byte_out(8'h77, 1'b0, "ignored byte");
      i_master.stop();
    end
    check(mem[5], 8'h85, "reg 05 untouched");
  endtask : foreign_addr

  // A START in mid-byte drops the byte: no write, no pointer step
  task automatic partial_abort;
    logic a;
    i_master.start();
    byte_out(8'hD0, 1'b1, "write address");
    byte_out(8'h20, 1'b1, "pointer");
    i_master.send(8'hC3, 5, a);
    i_master.start();
    byte_out(8'hD1, 1'b1, "address after abort");
    byte_in(1'b1, 8'hA0, "reg 20 unchanged");
    i_master.stop();
  endtask : partial_abort

  // Hang guard
  always @(negedge clk) begin
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    for (int i = 0; i < 64; i++) mem[i] = {2'b10, 6'(i)};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    read_from_reset();
    write_wrap();
    pointer_then_read();
    foreign_addr();
    partial_abort();
    tally_and_finish();
  end
endmodule : serial_slave_register_port_bench
